// >>> bench/sixct_pin_model.sv
// Purpose: Far-side pins of the six-channel timer
// Assumes: drv is the port level whenever the timer lets a pin go
// Notes:   External clock stands still outside a burst, so no stray ticks
`timescale 1ns/1ps
module sixct_pin_model
	import sixct_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       ext_run,
	input  wire logic [5:0] drv,
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	output logic      [5:0] pin_in,
	output logic            ext_clock_pin
);
	// ----
	// Pin levels
	// ----
	logic [2:0] ph = 3'h0;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
	always @(posedge sys_clk) ph <= ext_run ? ph + 3'h1 : 3'h0;
	assign ext_clock_pin = ext_run & ph[2];
endmodule : sixct_pin_model

// >>> bench/sixct_tb.sv
// Purpose: Self-checking bench for the six-channel timer
// Assumes: Strobes change just after the rising edge
// Notes:   Free-running counts allow a few ticks of bus latency
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
	import sixct_pkg::*;
	logic        sys_clk, rstn, reg_wr, reg_rd, ext_run, break_state, wrap_irq, ext_clk;
	logic [5:0]  reg_addr, drv, pin_in, pin_out, pin_oe, chan_irq, pre;
	logic [7:0]  reg_wdata, reg_rdata, d, v1;
	logic [15:0] c, c2;
	int          err_total = 0, cmp_count = 0, cyc = 0, n, m, lows;
	integer      seed = 63;
	int          caps [3] = '{1, 4, 5};
	sixct_timer #(.NCH(SIXCT_CH)) sixct_timer_i (.sys_clk(sys_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_clock_pin(ext_clk), .break_state(break_state),
		.chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
		.wrap_irq(wrap_irq), .chan_irq(chan_irq));
	sixct_pin_model sixct_pin_model_i (.sys_clk(sys_clk), .ext_run(ext_run), .drv(drv),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_clock_pin(ext_clk));
	// ----
	// Clock, timeout, bus tasks
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic rdcnt(output logic [15:0] v);
		logic [7:0] h, l;
		rd(ADDR_CNT_HI, h);
		rd(ADDR_CNT_LO, l);
		v = {h, l};
	endtask : rdcnt
	task automatic caps_chk(input logic [2:0] e);
		logic [7:0] f;
		for (int j = 0; j < 3; j++) begin
			rd(csc(caps[j]), f);
			`CHK("cap flag", e[j], f[CH_FLAG])
		end
	endtask : caps_chk
	function automatic logic [5:0] csc(input int k);
		return 6'(ADDR_CH_BASE + ADDR_CH_STRIDE * k);
	endfunction : csc
	function automatic logic [7:0] sc_exp(input logic f, ie, h, input logic [2:0] ps);
		return {f, ie, h, 2'h0, ps};
	endfunction : sc_exp
	function automatic logic pin_exp(input int code, input logic p);
		return (code == 1) ? ~p : 1'(code == 3);
	endfunction : pin_exp
	// ----
	// Main sequence
	// ----
	initial begin
		{reg_wr, reg_rd, ext_run, break_state, rstn} = 5'h00;
		reg_addr = 6'h00;
		reg_wdata = 8'h00;
		drv = 6'h00;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(ADDR_SC, d);
		`CHK("sc reset", sc_exp(0, 0, 1, 0), d)
		rd(ADDR_MOD_HI, d);
		`CHK("mod reset", 8'hFF, d)
		for (int k = 0; k < 6; k++) begin
			rd(csc(k), d);
			`CHK("chan reset", 8'h00, d)
		end
		rd(6'h3F, d);
		`CHK("unmapped", 8'h00, d)
		wr(ADDR_CNT_LO, 8'h55);
		repeat (20) @(posedge sys_clk);
		rdcnt(c);
		`CHK("halted cnt", 16'h0000, c)
		$display("reset test done");
		for (int p = 0; p < 7; p++) begin
			wr(ADDR_SC, 8'h30 | 8'(p));
			wr(ADDR_SC, 8'h10 | 8'(p));
			repeat (16 << p) @(posedge sys_clk);
			wr(ADDR_SC, 8'h20 | 8'(p));
			rdcnt(c);
			`CHK("prescale", 1'b1, c >= 16'h000F && c <= 16'h0014)
			rd(ADDR_SC, d);
			`CHK("clear bit", sc_exp(0, 0, 1, 3'(p)), d)
		end
		wr(ADDR_SC, 8'h30);
		rdcnt(c);
		`CHK("halt clear", 16'h0000, c)
		wr(ADDR_SC, 8'h10);
		@(posedge sys_clk) break_state <= 1'b1;
		rdcnt(c);
		repeat (30) @(posedge sys_clk);
		rdcnt(c2);
		`CHK("break", c, c2)
		break_state <= 1'b0;
		wr(ADDR_SC, 8'h37);
		wr(ADDR_SC, 8'h17);
		n = ($random(seed) & 7) + 1;
		@(posedge sys_clk) ext_run <= 1'b1;
		repeat (8 * n) @(posedge sys_clk);
		ext_run <= 1'b0;
		repeat (10) @(posedge sys_clk);
		wr(ADDR_SC, 8'h27);
		rdcnt(c);
		`CHK("ext count", 16'(n), c)
		wr(ADDR_SC, 8'h36);
		wr(ADDR_SC, 8'h16);
		repeat (100) @(posedge sys_clk);
		rdcnt(c);
		rd(ADDR_CNT_HI, d);
		repeat (200) @(posedge sys_clk);
		rd(ADDR_CNT_HI, d);
		rd(ADDR_CNT_LO, d);
		`CHK("latch", 1'b1, 8'(d - c[7:0]) <= 8'h01)
		$display("counter test done");
		m = ($random(seed) & 7) + 3;
		wr(ADDR_SC, 8'h30);
		wr(ADDR_MOD_HI, 8'h00);
		wr(ADDR_SC, 8'h40);
		repeat (300) @(posedge sys_clk);
		rd(ADDR_SC, d);
		`CHK("wrap held", sc_exp(0, 1, 0, 0), d)
		wr(ADDR_SC, 8'h70);
		wr(ADDR_MOD_LO, 8'(m));
		wr(ADDR_SC, 8'h40);
		repeat (3 * m + 3) @(posedge sys_clk);
		`CHK("wrap irq", 1'b1, wrap_irq)
		wr(ADDR_SC, 8'h60);
		rdcnt(c);
		`CHK("wrap bound", 1'b1, c <= 16'(m))
		rd(ADDR_SC, d);
		`CHK("no arm", sc_exp(1, 1, 1, 0), d)
		wr(ADDR_SC, 8'h60);
		rd(ADDR_SC, d);
		`CHK("cleared", sc_exp(0, 1, 1, 0), d)
		wr(ADDR_SC, 8'h40);
		repeat (3 * m) @(posedge sys_clk);
		rd(ADDR_SC, d);
		repeat (2 * m + 2) @(posedge sys_clk);
		wr(ADDR_SC, 8'h60);
		rd(ADDR_SC, d);
		`CHK("late clear", 1'b1, d[SC_WRAP_FLAG])
		$display("wrap test done");
		// halt and clear before mode change
		wr(ADDR_SC, 8'h30);
		wr(ADDR_MOD_LO, 8'h09);
		for (int k = 0; k < 5; k++) begin
			wr(csc(k) + 6'h01, 8'h00);
			wr(csc(k) + 6'h02, 8'h04);
			wr(csc(k), (k == 1 ? 8'h00 : 8'h40) | (k < 4 ? 8'h10 : 8'h00) | 8'((k & 3) << 2));
		end
		#1 pre = pin_out;
		`CHK("preset lo", 2'h0, {pin_out[0], pin_oe[0]})
		`CHK("preset hi", 2'h2, {pin_out[4], pin_oe[4]})
		wr(ADDR_SC, 8'h00);
		repeat (4) @(posedge sys_clk);
		wr(ADDR_SC, 8'h20);
		for (int k = 1; k < 4; k++) begin
			rd(csc(k), d);
			`CHK("cmp flag", 1'b1, d[CH_FLAG])
			`CHK("cmp pin", pin_exp(k, pre[k]), pin_out[k])
			`CHK("cmp oe", 1'b1, pin_oe[k])
			`CHK("cmp irq", 1'(k != 1), chan_irq[k])
		end
		wr(ADDR_SC, 8'h30);
		wr(csc(2), 8'h5B);
		wr(csc(3), 8'h5E);
		wr(ADDR_SC, 8'h00);
		repeat (40) @(posedge sys_clk);
		lows = 0;
		n = 0;
		repeat (20) begin
			@(posedge sys_clk);
			#1 lows += !pin_out[2];
			n += !pin_out[3];
		end
		`CHK("full duty", 0, lows)
		`CHK("wrap toggle", 1'b1, n > 0 && n < 20)
		$display("compare test done");
		wr(ADDR_SC, 8'h30);
		wr(csc(1), 8'h0C);
		wr(csc(4), 8'h04);
		wr(csc(5), 8'h08);
		for (int j = 0; j < 3; j++) begin
			rd(csc(caps[j]), d);
			wr(csc(caps[j]), d & 8'h7F);
		end
		@(posedge sys_clk) drv <= 6'h32;
		repeat (8) @(posedge sys_clk);
		drv <= 6'h00;
		repeat (8) @(posedge sys_clk);
		caps_chk(3'h0);
		wr(ADDR_SC, 8'h00);
		@(posedge sys_clk) drv <= 6'h32;
		repeat (8) @(posedge sys_clk);
		caps_chk(3'h3);
		wr(csc(1), 8'h0C);
		wr(csc(4), 8'h04);
		@(posedge sys_clk) drv <= 6'h00;
		repeat (8) @(posedge sys_clk);
		caps_chk(3'h5);
		rd(csc(4) + 6'h01, d);
		rd(csc(4) + 6'h02, v1);
		`CHK("cap value", 1'b1, d == 8'h00 && v1 <= 8'h09)
		rd(csc(4) + 6'h01, d);
		@(posedge sys_clk) drv <= 6'h10;
		repeat (8) @(posedge sys_clk);
		rd(csc(4) + 6'h02, d);
		`CHK("cap block", v1, d)
		$display("capture test done");
		wr(ADDR_SC, 8'h30);
		wr(csc(0), 8'h28);
		wr(csc(1), 8'h5C);
		rd(csc(1), d);
		`CHK("odd off", 8'h00, d)
		`CHK("pair oe", 2'h2, {pin_oe[0], pin_oe[1]})
		$display("buffered test done");
		final_report();
	end
endmodule : testbench

// >>> rtl/sixct_pkg.sv
// Purpose: Constants, modes and state layout of the six-channel timer
// Assumes: Byte-wide register port, one register per address
// Notes:   Functional notes follow
package sixct_pkg;
	localparam int         SIXCT_CH       = 6;
	localparam int         SIXCT_PAIRS    = 3;
	localparam int         ADDR_CH_STRIDE = 3;
	localparam logic [5:0] ADDR_SC        = 6'h00;
	localparam logic [5:0] ADDR_CNT_HI    = 6'h01;
	localparam logic [5:0] ADDR_CNT_LO    = 6'h02;
	localparam logic [5:0] ADDR_MOD_HI    = 6'h03;
	localparam logic [5:0] ADDR_MOD_LO    = 6'h04;
	localparam logic [5:0] ADDR_CH_BASE   = 6'h05;
	localparam int         SC_WRAP_FLAG   = 7;
	localparam int         SC_WRAP_IE     = 6;
	localparam int         SC_HALT        = 5;
	localparam int         SC_CLEAR       = 4;
	localparam int         CH_FLAG        = 7;
	localparam int         CH_IE          = 6;
	localparam int         CH_BUF         = 5;
	localparam int         CH_MSA         = 4;
	localparam int         CH_ELS_HI      = 3;
	localparam int         CH_TOV         = 1;
	localparam int         CH_FMAX        = 0;
	localparam logic [15:0] MOD_RESET     = 16'hFFFF;
	localparam logic        HALT_RESET    = 1'b1;
	localparam logic [2:0]  PS_EXT        = 3'h7;
	localparam logic [1:0]  ELS_TOGGLE    = 2'h1;
	localparam logic [1:0]  ELS_CLEAR     = 2'h2;
	localparam logic [1:0]  ELS_SET       = 2'h3;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_CAPTURE, MODE_COMPARE, MODE_BUFFERED, MODE_DISABLED
	} sixct_mode_e;

	typedef struct packed {
		logic        flag;
		logic        arm;
		logic        irq_en;
		logic        buf_sel;
		logic        ms_a;
		logic [1:0]  els;
		logic        tov;
		logic        fmax;
		logic        max_act;
		logic        cap_blk;
		logic        cmp_blk;
		logic        out;
		logic        s1;
		logic        s2;
		logic        s3;
		logic        lvl;
		logic [15:0] val;
	} sixct_chan_s;

	typedef struct packed {
		sixct_chan_s [SIXCT_CH-1:0]    chan;
		logic [15:0]                   cnt;
		logic [15:0]                   modv;
		logic [5:0]                    presc;
		logic [2:0]                    ps;
		logic                          halt;
		logic                          wrap_flag;
		logic                          wrap_arm;
		logic                          wrap_ie;
		logic                          mod_pend;
		logic                          lo_latched;
		logic [7:0]                    lo_buf;
		logic                          ext_s1;
		logic                          ext_s2;
		logic                          ext_s3;
		logic                          ext_lvl;
		logic [SIXCT_PAIRS-1:0]        latest_odd;
		logic [SIXCT_PAIRS-1:0]        act_odd;
		logic [7:0]                    rdata;
	} sixct_state_s;
endpackage : sixct_pkg

// >>> rtl/sixct_timer.sv
// Purpose: Six-channel 16-bit timer with capture, compare and PWM
// Assumes: sys_clk 100 MHz, rstn asynchronous active low
// Notes:   Pins are split into in, out and enable; enable low means port use
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module sixct_timer
	import sixct_pkg::*;
#(
	parameter int NCH = SIXCT_CH
) (
	input  logic           sys_clk,
	input  logic           rstn,
	input  logic [5:0]     reg_addr,
	input  logic [7:0]     reg_wdata,
	input  logic           reg_wr,
	input  logic           reg_rd,
	output logic [7:0]     reg_rdata,
	input  logic           ext_clock_pin,
	input  logic           break_state,
	input  logic [NCH-1:0] chan_pin_in,
	output logic [NCH-1:0] chan_pin_out,
	output logic [NCH-1:0] chan_pin_oe,
	output logic           wrap_irq,
	output logic [NCH-1:0] chan_irq
);

	// ------------------------------------------------------------
	// Checks and helpers
	// ------------------------------------------------------------
	if (NCH != SIXCT_CH) begin : g_bad_nch
		$error("sixct_timer: channel count must match the state layout");
	end

	function automatic logic [5:0] chan_addr(input int ch, input int k);
		return ADDR_CH_BASE + 6'(ch * ADDR_CH_STRIDE + k);
	endfunction : chan_addr

	function automatic sixct_mode_e mode_of(input sixct_chan_s c, input logic off);
		if (off)
			return MODE_DISABLED;
		else if (c.els == 2'h0)
			return MODE_OFF;
		else if (c.buf_sel)
			return MODE_BUFFERED;
		else if (c.ms_a)
			return MODE_COMPARE;
		else
			return MODE_CAPTURE;
	endfunction : mode_of

	sixct_state_s      q;
	sixct_state_s      n;
	logic [5:0]        ps_mask;
	logic              ext_edge;
	logic              tick;
	logic              clear_wr;
	logic              run;
	logic              at_mod;
	logic              wrap_ev;
	logic              wrap_set;
	logic [NCH-1:0]    dis;
	logic [NCH-1:0]    cmp_hold;
	logic [NCH-1:0]    rise;
	logic [NCH-1:0]    fall;
	logic [NCH-1:0]    cap_ev;
	logic [NCH-1:0]    match;
	logic [NCH-1:0]    set_ev;
	logic [15:0]       cmp_val [NCH];
	sixct_mode_e       mode    [NCH];

	// ------------------------------------------------------------
	// Counter clock
	// ------------------------------------------------------------
	// clock source select
	assign ps_mask  = 6'((7'h01 << q.ps) - 7'h01);
	assign ext_edge = (q.ext_s2 == q.ext_s3) && q.ext_s2 && !q.ext_lvl;
	assign tick     = (q.ps == PS_EXT) ? ext_edge : ((q.presc & ps_mask) == ps_mask);
	assign clear_wr = reg_wr && (reg_addr == ADDR_SC) && reg_wdata[SC_CLEAR];
	assign run      = tick && !q.halt && !break_state && !clear_wr;
	assign at_mod   = (q.cnt == q.modv);
	assign wrap_ev  = run && at_mod;
	assign wrap_set = wrap_ev && !q.mod_pend;

	// ------------------------------------------------------------
	// Per-channel decode
	// ------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		if (g % 2 == 1) begin : g_odd
			assign dis[g]      = q.chan[g-1].buf_sel;
			assign cmp_val[g]  = q.chan[g].val;
			assign cmp_hold[g] = q.chan[g].cmp_blk;
		end else begin : g_even
			logic use_odd;
			assign use_odd     = q.chan[g].buf_sel && q.act_odd[g/2];
			assign dis[g]      = 1'b0;
			assign cmp_val[g]  = use_odd ? q.chan[g+1].val : q.chan[g].val;
			assign cmp_hold[g] = use_odd ? q.chan[g+1].cmp_blk : q.chan[g].cmp_blk;
		end
		assign mode[g]   = mode_of(q.chan[g], dis[g]);
		assign rise[g]   = (q.chan[g].s2 == q.chan[g].s3) && q.chan[g].s2 && !q.chan[g].lvl;
		assign fall[g]   = (q.chan[g].s2 == q.chan[g].s3) && !q.chan[g].s2 && q.chan[g].lvl;
		assign cap_ev[g] = (mode[g] == MODE_CAPTURE) && !q.halt && !break_state
		                   && !q.chan[g].cap_blk
		                   && ((q.chan[g].els[0] && rise[g]) || (q.chan[g].els[1] && fall[g]));
		assign match[g]  = run && (q.cnt == cmp_val[g]) && !cmp_hold[g];
		assign set_ev[g] = cap_ev[g] || (match[g]
		                   && (mode[g] == MODE_COMPARE || mode[g] == MODE_BUFFERED));
		// pin only driven in compare modes
		assign chan_pin_oe[g]  = (mode[g] == MODE_COMPARE) || (mode[g] == MODE_BUFFERED);
		assign chan_pin_out[g] = q.chan[g].out;
		assign chan_irq[g]     = q.chan[g].flag && q.chan[g].irq_en && !dis[g];
	end

	assign wrap_irq  = q.wrap_flag && q.wrap_ie;
	assign reg_rdata = q.rdata;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic fm;
		fm = 1'b0;
		n = q;
		n.rdata  = 8'h00;
		n.ext_s1 = ext_clock_pin;
		n.ext_s2 = q.ext_s1;
		n.ext_s3 = q.ext_s2;
		if (q.ext_s2 == q.ext_s3)
			n.ext_lvl = q.ext_s2;
		n.presc = q.presc + 6'h01;
		// count up and wrap to zero
		if (run)
			n.cnt = at_mod ? 16'h0000 : q.cnt + 16'h0001;
		if (wrap_set) begin
			n.wrap_flag = 1'b1;
			n.wrap_arm  = 1'b0;
		end
		// buffered source swaps at period start
		if (wrap_ev)
			n.act_odd = q.latest_odd;

		for (int i = 0; i < NCH; i++) begin
			n.chan[i].s1 = chan_pin_in[i];
			n.chan[i].s2 = q.chan[i].s1;
			n.chan[i].s3 = q.chan[i].s2;
			if (q.chan[i].s2 == q.chan[i].s3)
				n.chan[i].lvl = q.chan[i].s2;
			if (set_ev[i]) begin
				n.chan[i].flag = 1'b1;
				n.chan[i].arm  = 1'b0;
			end
			if (cap_ev[i])
				n.chan[i].val = q.cnt;
			fm = q.chan[i].fmax && q.chan[i].tov && (q.chan[i].els == ELS_CLEAR);
			case (mode[i])
				MODE_COMPARE, MODE_BUFFERED: begin
					// wrap action wins, full duty per period
					if (wrap_ev && q.chan[i].tov) begin
						n.chan[i].out     = (fm || q.chan[i].max_act) ? 1'b1 : !q.chan[i].out;
						n.chan[i].max_act = fm;
					end else if (match[i] && !q.chan[i].max_act) begin
						case (q.chan[i].els)
							ELS_TOGGLE: n.chan[i].out = !q.chan[i].out;
							ELS_CLEAR:  n.chan[i].out = 1'b0;
							ELS_SET:    n.chan[i].out = 1'b1;
							default:    n.chan[i].out = q.chan[i].out;
						endcase
					end
				end
				MODE_OFF: begin
					n.chan[i].out     = !q.chan[i].ms_a;
					n.chan[i].max_act = 1'b0;
				end
				default: n.chan[i].max_act = 1'b0;
			endcase
		end

		// Register reads, data returned next cycle
		if (reg_rd) begin
			case (reg_addr)
				ADDR_SC: begin
					n.rdata = {q.wrap_flag, q.wrap_ie, q.halt, 2'h0, q.ps};
					n.wrap_arm = q.wrap_flag && !wrap_set;
				end
				ADDR_CNT_HI: begin
					n.rdata = q.cnt[15:8];
					if (!q.lo_latched) begin
						n.lo_buf     = q.cnt[7:0];
						n.lo_latched = 1'b1;
					end
				end
				ADDR_CNT_LO: begin
					n.rdata      = q.lo_latched ? q.lo_buf : q.cnt[7:0];
					n.lo_latched = 1'b0;
				end
				ADDR_MOD_HI: n.rdata = q.modv[15:8];
				ADDR_MOD_LO: n.rdata = q.modv[7:0];
				default:     n.rdata = 8'h00;
			endcase
			for (int i = 0; i < NCH; i++) begin
				if (reg_addr == chan_addr(i, 0) && !dis[i]) begin
					n.rdata = {q.chan[i].flag, q.chan[i].irq_en, q.chan[i].buf_sel,
					           q.chan[i].ms_a, q.chan[i].els, q.chan[i].tov, q.chan[i].fmax};
					// arm clearing on read while set
					n.chan[i].arm = q.chan[i].flag && !set_ev[i];
				end
				if (reg_addr == chan_addr(i, 1)) begin
					n.rdata = q.chan[i].val[15:8];
					if (mode[i] == MODE_CAPTURE)
						n.chan[i].cap_blk = 1'b1;
				end
				if (reg_addr == chan_addr(i, 2)) begin
					n.rdata = q.chan[i].val[7:0];
					n.chan[i].cap_blk = 1'b0;
				end
			end
		end

		// Register writes; counter bytes have no write path
		if (reg_wr) begin
			case (reg_addr)
				ADDR_SC: begin
					if (!reg_wdata[SC_WRAP_FLAG] && q.wrap_arm && !wrap_set)
						n.wrap_flag = 1'b0;
					n.wrap_arm = 1'b0;
					n.wrap_ie  = reg_wdata[SC_WRAP_IE];
					n.halt     = reg_wdata[SC_HALT];
					n.ps       = reg_wdata[2:0];
				end
				ADDR_MOD_HI: begin
					n.modv[15:8] = reg_wdata;
					n.mod_pend   = 1'b1;
				end
				ADDR_MOD_LO: begin
					n.modv[7:0] = reg_wdata;
					n.mod_pend  = 1'b0;
				end
				default: n.mod_pend = q.mod_pend;
			endcase
			for (int i = 0; i < NCH; i++) begin
				if (reg_addr == chan_addr(i, 0) && !dis[i]) begin
					// zero write clears only when armed
					if (!reg_wdata[CH_FLAG] && q.chan[i].arm && !set_ev[i])
						n.chan[i].flag = 1'b0;
					n.chan[i].arm     = 1'b0;
					n.chan[i].irq_en  = reg_wdata[CH_IE];
					// buffered bit only on even channels
					n.chan[i].buf_sel = (i % 2 == 0) ? reg_wdata[CH_BUF] : 1'b0;
					n.chan[i].ms_a    = reg_wdata[CH_MSA];
					n.chan[i].els     = reg_wdata[CH_ELS_HI -: 2];
					n.chan[i].tov     = reg_wdata[CH_TOV];
					n.chan[i].fmax    = reg_wdata[CH_FMAX];
				end
				if (reg_addr == chan_addr(i, 1)) begin
					n.chan[i].val[15:8] = reg_wdata;
					if (mode[i] != MODE_CAPTURE)
						n.chan[i].cmp_blk = 1'b1;
				end
				if (reg_addr == chan_addr(i, 2)) begin
					n.chan[i].val[7:0] = reg_wdata;
					n.chan[i].cmp_blk  = 1'b0;
				end
				if (reg_addr == chan_addr(i, 1) || reg_addr == chan_addr(i, 2)) begin
					if (i % 2 == 1 && dis[i])
						n.latest_odd[i/2] = 1'b1;
					else if (i % 2 == 0 && q.chan[i].buf_sel)
						n.latest_odd[i/2] = 1'b0;
				end
			end
		end

		if (clear_wr) begin
			n.cnt        = 16'h0000;
			n.presc      = 6'h00;
			n.lo_latched = 1'b0;
			n.lo_buf     = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q      <= '0;
			q.modv <= MOD_RESET;
			q.halt <= HALT_RESET;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_clear_zero: assert property (clear_wr |=> q.cnt == 16'h0000 && q.presc == 6'h00)
		else $error("counter_clear did not zero counter");
	a_clear_reads: assert property (reg_rd && reg_addr == ADDR_SC |=> !reg_rdata[SC_CLEAR])
		else $error("counter_clear read back as one");
	a_halt_clear: assert property (clear_wr && reg_wdata[SC_HALT]
		|=> q.cnt == 16'h0000 ##1 q.cnt == 16'h0000 || clear_wr)
		else $error("halt with clear did not hold zero");
	a_halt_stable: assert property (q.halt && !clear_wr |=> $stable(q.cnt))
		else $error("counter moved while halted");
	a_cap_halt: assert property (q.halt && mode[0] == MODE_CAPTURE && !reg_wr
		|=> $stable(q.chan[0].val))
		else $error("capture while halted");
	a_lo_latch: assert property (reg_rd && reg_addr == ADDR_CNT_HI && !q.lo_latched
		|=> q.lo_latched && q.lo_buf == $past(q.cnt[7:0]))
		else $error("low byte not latched on high read");
	a_wrap_zero: assert property (wrap_ev && !clear_wr |=> q.cnt == 16'h0000
		&& (q.wrap_flag || $past(q.mod_pend)))
		else $error("wrap did not restart at zero");
	a_mod_pend: assert property (q.mod_pend && !q.wrap_flag |=> !q.wrap_flag)
		else $error("wrap flag set while modulo pending");
	a_flag_keep: assert property (q.chan[0].flag && !(reg_wr && reg_addr == chan_addr(0, 0))
		|=> q.chan[0].flag)
		else $error("channel flag lost without clear");
	a_flag_event: assert property (set_ev[0] |=> q.chan[0].flag)
		else $error("channel event lost");
	a_odd_off: assert property (q.chan[0].buf_sel |-> !chan_pin_oe[1] && !chan_irq[1])
		else $error("odd channel active while linked");
	a_wrap_prio: assert property (wrap_ev && q.chan[0].tov && q.chan[0].max_act == 1'b0
		&& !q.chan[0].fmax && mode[0] == MODE_COMPARE && !clear_wr && !reg_wr
		|=> chan_pin_out[0] != $past(chan_pin_out[0]))
		else $error("wrap toggle lost to compare");

	c_wrap:     cover property (wrap_set);
	c_capture:  cover property (cap_ev[0]);
	c_buffered: cover property (match[0] && mode[0] == MODE_BUFFERED);
	c_full:     cover property (q.chan[0].max_act && wrap_ev);

endmodule : sixct_timer
